// file: interrupt_fp_exception_unit.sv
// Interrupt and floating-point exception recognition with an AXI4-Lite register file.
// Assumes a core that pulses boundary once per instruction boundary and a coprocessor on the same clock.
//
// Operation
// - Take interrupt immediately when any unmasked hardware or software source is active; the unit waits for the next boundary pulse and needs IE set.
// - Each pending source shows as its own cause bit, ordered by input number.
// - After a floating-point interrupt, return address is the fp instruction or branch.
// - Delay-slot flag set when exception hits a delay slot; instruction at address plus four.
// - Floating-point instruction with coprocessor usable clear raises coprocessor unusable exception.
// - Coprocessor sets unimplemented flag in its status register when it cannot perform.
// - Coprocessor exception with unimplemented clear is recorded as an arithmetic exception.
// - One variant routes fp exceptions to an interrupt line, other through exception path.
//
// Design decisions made here: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "exc_unit_regs.svh"

module interrupt_fp_exception_unit #(
  parameter int HW_IRQS         = 6,
  parameter int FP_IRQ_LINE     = 3,
  parameter bit FP_VIA_IRQ      = 1'b1
) (
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic [5:0]                irq_pin,
  input  wire logic                      boundary,
  input  wire logic [31:0]               boundary_pc,
  input  wire logic                      boundary_in_slot,
  input  wire logic [31:0]               boundary_branch_pc,
  input  wire logic                      boundary_is_fp,
  input  wire logic                      fp_exception,
  input  wire logic                      fp_cannot_perform,
  input  wire logic [31:0]               fp_instr_pc,
  input  wire logic                      fp_instr_in_slot,
  input  wire logic [31:0]               fp_branch_pc,
  output logic                           exc_take,
  output exc_unit_pkg::exc_code_t        exc_code,
  output logic [31:0]                    exc_vector_epc,
  input  wire logic [7:0]                s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [7:0]                s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready
);

  initial begin
    if (HW_IRQS != 6 || FP_IRQ_LINE < 0 || FP_IRQ_LINE >= HW_IRQS) begin
      $error("Unsupported interrupt configuration.");
    end
  end

  function automatic logic [31:0] apply_strb(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic is_mapped(input logic [7:0] addr);
    return addr == `OFS_STATUS || addr == `OFS_CAUSE || addr == `OFS_RETURN_ADDR || addr == `OFS_FP_CSR;
  endfunction

  logic [5:0]  irq_meta;
  logic [5:0]  irq_sync;
  logic [31:0] status;
  logic [1:0]  sw_irq;
  logic [31:0] return_addr;
  logic        cause_bd;
  logic [4:0]  cause_code;
  logic        fp_event;
  logic        fp_ieee;
  logic        fp_unimplemented_op_flag;
  logic        fp_trap_armed;
  logic [31:0] fp_saved_pc;
  logic        fp_saved_slot;
  logic [31:0] fp_saved_branch;
  logic        aw_held;
  logic [7:0]  aw_addr;
  logic        w_held;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        wr_en;
  logic [5:0]  hw_pend;
  logic [7:0]  pend;
  logic        irq_req;
  logic        cp_unusable;
  logic        fp_trap;
  logic        fp_sig;
  logic        take_now;
  logic        use_fp_addr;
  logic        next_bd;
  logic [31:0] next_epc;
  exc_unit_pkg::exc_code_t next_code;
  logic [31:0] cause_word;
  logic [31:0] fp_csr_word;

  // Pins are asynchronous and pass two flip-flops first.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_meta <= 6'h00;
      irq_sync <= 6'h00;
    end else begin
      irq_meta <= irq_pin;
      irq_sync <= irq_meta;
    end
  end

  assign fp_sig  = fp_exception & status[`STATUS_CU1_BIT];
  assign wr_en   = aw_held & w_held & ~s_axi_bvalid;

  always_comb begin
    hw_pend = irq_sync;
    if (FP_VIA_IRQ) begin
      hw_pend[FP_IRQ_LINE] = irq_sync[FP_IRQ_LINE] | fp_event;
    end
  end

  assign pend        = {hw_pend, sw_irq};
  assign irq_req     = status[`STATUS_IE_BIT] & |(pend & status[`STATUS_IM_LSB +: 8]);
  assign cp_unusable = boundary_is_fp & ~status[`STATUS_CU1_BIT];
  assign fp_trap     = !FP_VIA_IRQ && fp_trap_armed;
  assign take_now    = boundary & (irq_req | cp_unusable | fp_trap);

  always_comb begin
    use_fp_addr = 1'b0;
    next_code   = exc_unit_pkg::EXC_INTERRUPT;
    if (irq_req) begin
      next_code   = exc_unit_pkg::EXC_INTERRUPT;
      use_fp_addr = FP_VIA_IRQ && fp_event && status[`STATUS_IM_LSB + 2 + FP_IRQ_LINE];
    end else if (cp_unusable) begin
      next_code   = exc_unit_pkg::EXC_CP_UNUSE;
    end else begin
      next_code   = exc_unit_pkg::EXC_FP_ARITH;
      use_fp_addr = 1'b1;
    end
    next_bd  = use_fp_addr ? fp_saved_slot : boundary_in_slot;
    if (use_fp_addr) begin
      next_epc = fp_saved_slot ? fp_saved_branch : fp_saved_pc;
    end else begin
      next_epc = boundary_in_slot ? boundary_branch_pc : boundary_pc;
    end
  end

  // Exception is signalled to the core one cycle after the boundary.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      exc_take       <= 1'b0;
      exc_code       <= exc_unit_pkg::EXC_INTERRUPT;
      exc_vector_epc <= 32'h0000_0000;
    end else begin
      exc_take <= take_now;
      if (take_now) begin
        exc_code       <= next_code;
        exc_vector_epc <= next_epc;
      end
    end
  end

  // Saved return address, delay-slot flag and cause code.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      return_addr <= 32'h0000_0000;
      cause_bd    <= 1'b0;
      cause_code  <= 5'h00;
    end else if (take_now) begin
      return_addr <= next_epc;
      cause_bd    <= next_bd;
      cause_code  <= next_code;
    end
  end

  // Status: taking an exception masks further interrupts.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status <= `STATUS_RESET;
    end else begin
      if (wr_en && aw_addr == `OFS_STATUS) begin
        status <= apply_strb(status, w_data, w_strb) & `STATUS_WR_MASK;
      end
      if (take_now) begin
        status[`STATUS_IE_BIT] <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sw_irq <= 2'h0;
    end else if (wr_en && aw_addr == `OFS_CAUSE) begin
      sw_irq <= w_strb[1] ? w_data[`CAUSE_PEND_LSB +: 2] : sw_irq;
    end
  end

  // Coprocessor flags; a new event wins over a write-one-to-clear in the same cycle.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fp_event <= 1'b0;
      fp_ieee  <= 1'b0;
      fp_unimplemented_op_flag <= 1'b0;
    end else begin
      if (wr_en && aw_addr == `OFS_FP_CSR) begin
        if (w_strb[0] && w_data[`FP_CSR_EVENT_BIT]) begin
          fp_event <= 1'b0;
        end
        if (w_strb[2] && w_data[`FP_CSR_IEEE_BIT]) begin
          fp_ieee <= 1'b0;
        end
        if (w_strb[2] && w_data[`FP_CSR_UNIMPLEMENTED_OP_FLAG_BIT]) begin
          fp_unimplemented_op_flag <= 1'b0;
        end
      end
      if (fp_sig) begin
        fp_event <= 1'b1;
        if (fp_cannot_perform) begin
          fp_unimplemented_op_flag <= 1'b1;
        end else begin
          fp_ieee <= 1'b1;
        end
      end
    end
  end

  // Faulting instruction capture and exception-path trap arming.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fp_trap_armed   <= 1'b0;
      fp_saved_pc     <= 32'h0000_0000;
      fp_saved_slot   <= 1'b0;
      fp_saved_branch <= 32'h0000_0000;
    end else begin
      if (take_now && !irq_req && !cp_unusable) begin
        fp_trap_armed <= 1'b0;
      end
      if (fp_sig) begin
        fp_trap_armed   <= 1'b1;
        fp_saved_pc     <= fp_instr_pc;
        fp_saved_slot   <= fp_instr_in_slot;
        fp_saved_branch <= fp_branch_pc;
      end
    end
  end

  assign cause_word  = {cause_bd, 15'h0000, pend, 1'b0, cause_code, 2'h0};
  assign fp_csr_word = {14'h0000, fp_unimplemented_op_flag, fp_ieee, 15'h0000, fp_event};

  // Write channel: address and data accepted in either order, response after both.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held       <= 1'b0;
      aw_addr       <= 8'h00;
      s_axi_awready <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held       <= 1'b1;
        aw_addr       <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (!aw_held && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
      end
      if (wr_en) begin
        aw_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held       <= 1'b0;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
      s_axi_wready <= 1'b0;
    end else begin
      if (s_axi_wvalid && s_axi_wready) begin
        w_held       <= 1'b1;
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (!w_held && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
      end
      if (wr_en) begin
        w_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end else if (wr_en) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= is_mapped(aw_addr) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read channel.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= is_mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
      unique case (s_axi_araddr)
        `OFS_STATUS:      s_axi_rdata <= {cause_bd, status[30:0]};
        `OFS_CAUSE:       s_axi_rdata <= cause_word;
        `OFS_RETURN_ADDR: s_axi_rdata <= return_addr;
        `OFS_FP_CSR:      s_axi_rdata <= fp_csr_word;
        default:          s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

endmodule

// file: exc_unit_regs.svh
// Register offsets, field positions, reset values and write masks of the exception unit.
// Assumes inclusion by its bare name from the exception unit design file.
`ifndef EXC_UNIT_REGS_SVH
`define EXC_UNIT_REGS_SVH

`define OFS_STATUS          8'h00
`define OFS_CAUSE           8'h04
`define OFS_RETURN_ADDR     8'h08
`define OFS_FP_CSR          8'h0C

`define STATUS_IE_BIT       0
`define STATUS_IM_LSB       8
`define STATUS_CU1_BIT      29
`define STATUS_BD_BIT       31
`define STATUS_WR_MASK      32'h2000_FF01
`define STATUS_RESET        32'h0000_0000

`define CAUSE_CODE_LSB      2
`define CAUSE_PEND_LSB      8
`define CAUSE_BD_BIT        31
`define CAUSE_SW_MASK       32'h0000_0300

`define FP_CSR_EVENT_BIT    0
`define FP_CSR_IEEE_BIT     16
`define FP_CSR_UNIMPLEMENTED_OP_FLAG_BIT    17

`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2

`endif

// file: exc_unit_pkg.sv
// Types shared by the exception unit.
// Assumes nothing of its surroundings.
package exc_unit_pkg;

  typedef enum logic [4:0] {
    EXC_INTERRUPT  = 5'b0_0000,
    EXC_CP_UNUSE   = 5'b0_1011,
    EXC_FP_ARITH   = 5'b0_1111
  } exc_code_t;

endpackage

// file: fp_irq_source.sv
// Model of the interrupting peripherals and the floating-point coprocessor.
// Assumes the bench calls its tasks from a process on the same clock.
`timescale 1ns/1ps

module fp_irq_source (
  input  wire logic        aclk,
  output logic [5:0]       irq_pin,
  output logic             fp_exception,
  output logic             fp_cannot_perform,
  output logic [31:0]      fp_instr_pc,
  output logic             fp_instr_in_slot,
  output logic [31:0]      fp_branch_pc
);
  initial begin
    irq_pin = 6'h00;
    fp_exception = 1'b0;
    fp_cannot_perform = 1'b0;
    fp_instr_pc = 32'h0000_0000;
    fp_instr_in_slot = 1'b0;
    fp_branch_pc = 32'h0000_0000;
  end

  // Drives the six level interrupt lines.
  task automatic pins(input logic [5:0] v);
    @(posedge aclk);
    irq_pin <= v;
  endtask

  // Signals one exception; unimplemented_op_flag marks an operation it cannot perform.
  task automatic fp_event(input logic unimplemented_op_flag, input logic [31:0] pc, input logic slot, input logic [31:0] br);
    @(posedge aclk);
    fp_exception <= 1'b1;
    fp_cannot_perform <= unimplemented_op_flag;
    fp_instr_pc <= pc;
    fp_instr_in_slot <= slot;
    fp_branch_pc <= br;
    @(posedge aclk);
    fp_exception <= 1'b0;
    fp_cannot_perform <= ~unimplemented_op_flag;
    fp_instr_pc <= ~pc;
    fp_instr_in_slot <= ~slot;
    fp_branch_pc <= ~br;
  endtask
endmodule

// file: exc_unit_props.sv
// Concurrent checks on the ports of the exception unit.
// Assumes binding to the unit; all checks run on aclk.
`timescale 1ns/1ps

module exc_unit_props (
  input wire logic                    aclk,
  input wire logic                    aresetn,
  input wire logic                    boundary,
  input wire logic [31:0]             boundary_pc,
  input wire logic                    boundary_in_slot,
  input wire logic [31:0]             boundary_branch_pc,
  input wire logic                    exc_take,
  input exc_unit_pkg::exc_code_t      exc_code,
  input wire logic [31:0]             exc_vector_epc,
  input wire logic                    s_axi_arvalid,
  input wire logic                    s_axi_arready,
  input wire logic [31:0]             s_axi_rdata,
  input wire logic                    s_axi_rvalid,
  input wire logic                    s_axi_rready,
  input wire logic                    s_axi_bvalid,
  input wire logic                    s_axi_bready
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence took_s;
    boundary ##1 exc_take;
  endsequence

  take_at_boundary_a: assert property (exc_take |-> $past(boundary)) else $error("take without boundary");
  code_legal_a: assert property (exc_take |-> exc_code inside {exc_unit_pkg::EXC_INTERRUPT,
    exc_unit_pkg::EXC_CP_UNUSE, exc_unit_pkg::EXC_FP_ARITH}) else $error("bad code");
  epc_unusable_a: assert property (took_s ##0 exc_code == exc_unit_pkg::EXC_CP_UNUSE |->
    exc_vector_epc == ($past(boundary_in_slot) ? $past(boundary_branch_pc) : $past(boundary_pc)))
    else $error("bad epc");
  epc_hold_a: assert property (!exc_take |-> $stable(exc_vector_epc)) else $error("epc moved");
  code_hold_a: assert property (!exc_take |-> $stable(exc_code)) else $error("code moved");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no read answer");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  bresp_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid stuck");
endmodule

bind interrupt_fp_exception_unit exc_unit_props u_props (.aclk(aclk), .aresetn(aresetn), .boundary(boundary),
  .boundary_pc(boundary_pc), .boundary_in_slot(boundary_in_slot), .boundary_branch_pc(boundary_branch_pc),
  .exc_take(exc_take), .exc_code(exc_code), .exc_vector_epc(exc_vector_epc), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready));

// file: testbench.sv
// Self-checking bench for the exception unit.
// Assumes the unit, its checker and the source model are compiled first.
`timescale 1ns/1ps
`include "exc_unit_regs.svh"

module testbench;
  logic aclk = 1'b0, aresetn = 1'b0, boundary = 1'b0, b_slot = 1'b0, b_fp = 1'b0;
  logic [31:0] b_pc = 32'h0000_0000, b_br = 32'h0000_0000, wdata = 32'h0000_0000, rdata, got;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, fpx, fpu, fps, take;
  logic [1:0] bresp, rresp, bresp_seen;
  logic [5:0] pins;
  logic [31:0] fpc, fbr, exception_return_address, epc_x;
  exc_unit_pkg::exc_code_t code, code_x;
  int fails = 0, n_compared = 0;

  always #2.5 aclk = ~aclk;

  fp_irq_source u_src (.aclk(aclk), .irq_pin(pins), .fp_exception(fpx), .fp_cannot_perform(fpu),
    .fp_instr_pc(fpc), .fp_instr_in_slot(fps), .fp_branch_pc(fbr));

  interrupt_fp_exception_unit u_dut (.aclk(aclk), .aresetn(aresetn), .irq_pin(pins), .boundary(boundary),
    .boundary_pc(b_pc), .boundary_in_slot(b_slot), .boundary_branch_pc(b_br), .boundary_is_fp(b_fp),
    .fp_exception(fpx), .fp_cannot_perform(fpu), .fp_instr_pc(fpc), .fp_instr_in_slot(fps),
    .fp_branch_pc(fbr), .exc_take(take), .exc_code(code), .exc_vector_epc(exception_return_address), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  interrupt_fp_exception_unit #(.FP_VIA_IRQ(1'b0)) u_dut_trap (.aclk(aclk), .aresetn(aresetn), .irq_pin(pins),
    .boundary(boundary), .boundary_pc(b_pc), .boundary_in_slot(b_slot), .boundary_branch_pc(b_br),
    .boundary_is_fp(b_fp), .fp_exception(fpx), .fp_cannot_perform(fpu), .fp_instr_pc(fpc),
    .fp_instr_in_slot(fps), .fp_branch_pc(fbr), .exc_take(), .exc_code(code_x), .exc_vector_epc(epc_x),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(),
    .s_axi_rdata(), .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready(rready));

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic chk_code(input exc_unit_pkg::exc_code_t g, input exc_unit_pkg::exc_code_t e);
    chk({27'h0, g}, {27'h0, e});
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit aw = 1, w = 1;
    @(posedge aclk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    while (aw || w) begin
      @(posedge aclk);
      if (aw && awready) begin aw = 0; awvalid <= 1'b0; end
      if (w && wready) begin w = 0; wvalid <= 1'b0; end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    bresp_seen = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    @(posedge aclk);
    rready <= 1'b1;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata; r = rresp; rready <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [1:0] r;
    rd(a, got, r);
    chk(got, e);
  endtask

  // One instruction boundary, then the taken exception is compared.
  task automatic bnd(input logic [31:0] pc, input logic s, input logic [31:0] br, input logic f,
                     input exc_unit_pkg::exc_code_t ec, input logic [31:0] ee);
    @(posedge aclk);
    boundary <= 1'b1; b_pc <= pc; b_slot <= s; b_br <= br; b_fp <= f;
    @(posedge aclk);
    boundary <= 1'b0; b_pc <= ~pc; b_slot <= ~s; b_br <= ~br;
    @(posedge aclk);
    chk({31'h0, take}, 32'h0000_0001);
    chk_code(code, ec);
    chk(exception_return_address, ee);
  endtask

  task automatic give_verdict;
    $display("compared %0d fails %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge aclk);
    fails++;
    give_verdict();
  end

  initial begin
    logic [1:0] r;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk(`OFS_STATUS, 32'h0000_0000);
    bnd(32'h0000_0100, 1'b0, 32'h0000_00FC, 1'b1, exc_unit_pkg::EXC_CP_UNUSE, 32'h0000_0100);
    bnd(32'h0000_0204, 1'b1, 32'h0000_0200, 1'b1, exc_unit_pkg::EXC_CP_UNUSE, 32'h0000_0200);
    rd_chk(`OFS_STATUS, 32'h8000_0000);
    wr(`OFS_STATUS, 32'h0000_FF01);
    chk({30'h0, bresp_seen}, {30'h0, `RESP_OKAY});
    u_src.pins(6'b00_0101);
    wr(`OFS_CAUSE, 32'h0000_0100);
    rd_chk(`OFS_CAUSE, 32'h8000_152C);
    bnd(32'h0000_0300, 1'b0, 32'h0000_02FC, 1'b0, exc_unit_pkg::EXC_INTERRUPT, 32'h0000_0300);
    rd_chk(`OFS_STATUS, 32'h0000_FF00);
    u_src.pins(6'b00_0000);
    wr(`OFS_CAUSE, 32'h0000_0000);
    wr(`OFS_STATUS, 32'h2000_FF01);
    u_src.fp_event(1'b1, 32'h0000_0404, 1'b1, 32'h0000_0400);
    rd_chk(`OFS_FP_CSR, 32'h0002_0001);
    rd_chk(`OFS_CAUSE, 32'h0000_2000);
    bnd(32'h0000_0500, 1'b0, 32'h0000_04FC, 1'b0, exc_unit_pkg::EXC_INTERRUPT, 32'h0000_0400);
    chk_code(code_x, exc_unit_pkg::EXC_FP_ARITH);
    chk(epc_x, 32'h0000_0400);
    rd_chk(`OFS_STATUS, 32'hA000_FF00);
    wr(`OFS_FP_CSR, 32'h0002_0001);
    u_src.fp_event(1'b0, 32'h0000_0600, 1'b0, 32'h0000_05FC);
    rd_chk(`OFS_FP_CSR, 32'h0001_0001);
    wr(8'h10, 32'hFFFF_FFFF);
    chk({30'h0, bresp_seen}, {30'h0, `RESP_SLVERR});
    rd(8'h10, got, r);
    chk({30'h0, r}, {30'h0, `RESP_SLVERR});
    give_verdict();
  end
endmodule
